// ==== inc/soft_reset_pkg.sv ====
// Constants shared by the soft reset and status register bank
package soft_reset_pkg;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int          HDR_BITS      = 8;
  localparam int          FRAME_BITS    = 24;
  localparam int          HDR_READ_BIT  = 7;
  localparam logic [4:0]  CNT_HDR_DONE  = 5'h08;
  localparam logic [4:0]  CNT_FRAME_END = 5'h18;
  localparam logic [4:0]  CNT_FIRST_SHIFT = 5'h09;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_SOFTWARE_RESET_TRIGGER = 6'h00;
  localparam logic [5:0] OFS_INTERRUPT_STATUS       = 6'h24;
  localparam logic [5:0] OFS_RESET_INDICATOR        = 6'h25;
  localparam logic [5:0] OFS_CURRENT_TIME_HIGH      = 6'h26;
  localparam logic [5:0] OFS_CURRENT_TIME_LOW       = 6'h27;
  localparam logic [5:0] OFS_GPIO_INPUT_LEVELS      = 6'h28;
  localparam logic [5:0] OFS_PART_IDENTIFIER        = 6'h2c;
  localparam logic [5:0] OFS_RECEIVE_STATUS         = 6'h2d;
  localparam logic [5:0] OFS_PACKET_TIMESTAMP_HIGH  = 6'h2e;
  localparam logic [5:0] OFS_PACKET_TIMESTAMP_LOW   = 6'h2f;
  localparam logic [5:0] OFS_BIT_ERROR_TEST_ENABLE  = 6'h30;
  localparam logic [5:0] OFS_POWER_SUPPLY_TEST_MODE = 6'h31;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          RESET_IND_BIT     = 7;
  localparam int          GPIO_IN_LSB       = 8;
  localparam int          CCA_FINAL_LSB     = 8;
  localparam int          BER_EN_BIT        = 15;
  localparam int          SUPPLY_SEL_LSB    = 2;
  localparam logic [15:0] RESET_TRIGGER_RST = 16'h0000;
  localparam logic        BER_EN_RST        = 1'b0;
  localparam logic [2:0]  SUPPLY_SEL_RST    = 3'h0;
  // Arbitrary identification value, not tied to any real part
  localparam logic [15:0] PART_ID_VALUE     = 16'h5a01;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_RECEIVE,
    MODE_TRANSMIT
  } op_mode_e;

endpackage

// ==== verilog/spi_frame_slave.sv ====
// Serial frame slave: header, 16-bit data word, shift out on read
`timescale 1ns/1ps
module spi_frame_slave (
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Power-on reset only
  input  wire logic        sclk_pin,     // Serial clock pin
  input  wire logic        mosi_pin,     // Serial data in pin
  input  wire logic        ce_n_pin,     // Chip enable pin, active low
  input  wire logic [15:0] rd_data,      // Read word, valid with hdr_pulse
  output logic             hdr_pulse,    // Header complete
  output logic             hdr_read,     // Header asks for a read
  output logic [5:0]       hdr_addr,     // Register offset
  output logic             wr_pulse,     // Write word complete
  output logic [15:0]      wr_data,      // Written word
  output logic             ce_active,    // Synchronised chip enable level
  output logic             miso,         // Serial data out
  output logic             miso_oe       // Serial data out enable
);

  logic [2:0]  sclk_sync;
  logic [1:0]  mosi_sync;
  logic [1:0]  ce_sync;
  logic [4:0]  cnt_reg;
  logic [23:0] shift_in_reg;
  logic [15:0] shift_out_reg;
  logic        rise;
  logic        fall;

  // ----------------------------------------------------------------
  // Pin synchronisers; edges come from the second and third stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_sync <= 3'h0;
      mosi_sync <= 2'h0;
      ce_sync   <= 2'h3;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk_pin};
      mosi_sync <= {mosi_sync[0], mosi_pin};
      ce_sync   <= {ce_sync[0], ce_n_pin};
    end
  end

  assign rise      = sclk_sync[1] & ~sclk_sync[2];
  assign fall      = ~sclk_sync[1] & sclk_sync[2];

  // Frame logic is cleared only by the power-on reset and by chip enable high, so a reset frame completes
  always_ff @(posedge clk) begin // R10
    if (rst || ce_sync[1]) begin
      cnt_reg      <= 5'h00;
      shift_in_reg <= 24'h000000;
    end else if (rise && cnt_reg != soft_reset_pkg::CNT_FRAME_END) begin
      cnt_reg      <= cnt_reg + 5'h01;
      shift_in_reg <= {shift_in_reg[22:0], mosi_sync[1]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hdr_pulse <= 1'b0;
      hdr_read  <= 1'b0;
      hdr_addr  <= 6'h00;
      wr_pulse  <= 1'b0;
      wr_data   <= 16'h0000;
      ce_active <= 1'b0;
    end else begin
      ce_active <= ~ce_sync[1];
      hdr_pulse <= 1'b0;
      wr_pulse  <= 1'b0;
      if (!ce_sync[1] && cnt_reg == soft_reset_pkg::CNT_HDR_DONE && !hdr_pulse && rise == 1'b0
          && shift_out_reg == 16'h0000 && !miso_oe) begin
        hdr_pulse <= 1'b1;
        hdr_read  <= shift_in_reg[soft_reset_pkg::HDR_READ_BIT];
        hdr_addr  <= shift_in_reg[5:0];
      end
      if (rise && !ce_sync[1] && !hdr_read && cnt_reg == soft_reset_pkg::CNT_FRAME_END - 5'h01) begin
        wr_pulse <= 1'b1;
        wr_data  <= {shift_in_reg[14:0], mosi_sync[1]};
      end
    end
  end

  // Read data leaves MSB first, changing on falling edges after the first data bit
  always_ff @(posedge clk) begin
    if (rst || ce_sync[1]) begin
      shift_out_reg <= 16'h0000;
      miso_oe       <= 1'b0;
      miso          <= 1'b0;
    end else if (hdr_pulse) begin
      shift_out_reg <= rd_data;
      miso_oe       <= hdr_read;
      miso          <= hdr_read & rd_data[15];
    end else if (fall && cnt_reg >= soft_reset_pkg::CNT_FIRST_SHIFT && miso_oe) begin
      shift_out_reg <= {shift_out_reg[14:0], 1'b0};
      miso          <= shift_out_reg[14];
    end
  end

endmodule // spi_frame_slave

// ==== verilog/soft_reset_regs.sv ====
// Soft reset trigger, status and test registers behind the serial port
// Operation
// R1: Any serial write to offset 00 starts a soft reset, data ignored.
// R2: Soft reset clears digital logic only; radio stays powered.
// R3: Soft reset forces the operating state machine to idle.
// R4: Soft reset returns every serial register to its default.
// R5: Soft reset leaves receive and transmit packet memories untouched.
// R6: Logic stays in reset while chip enable remains low.
// R7: Host raises chip enable to end reset; device then resumes.
// R8: Reading offset 00 has no side effect and triggers nothing.
// R9: Reset trigger register reads all zero.
// R10: Serial interface logic is excluded from the soft reset.
`timescale 1ns/1ps
module soft_reset_regs (
  input  wire logic        clk,                 // 200 MHz system clock
  input  wire logic        rst,                 // Power-on reset, synchronous
  input  wire logic        spi_clk,             // Serial clock pin
  input  wire logic        spi_mosi,            // Serial data in pin
  input  wire logic        spi_ce_n,            // Chip enable pin, active low
  output logic             spi_miso,            // Serial data out pin
  output logic             spi_miso_oe,         // Serial data out enable
  input  wire logic [15:0] irq_flags,           // Interrupt status from core
  input  wire logic [23:0] current_time,        // Event timer value
  input  wire logic [6:0]  gpio_pins,           // GPIO input pins
  input  wire logic [7:0]  cca_final,           // Compensated energy result
  input  wire logic [6:0]  rx_pkt_length,       // Latched receive length
  input  wire logic [23:0] timestamp,           // Packet timestamp
  input  wire logic        rx_start,            // Sequencer asks for receive
  input  wire logic        tx_start,            // Sequencer asks for transmit
  input  wire logic        seq_done,            // Sequence finished
  output logic             logic_reset,         // Digital core reset
  output logic             radio_powered,       // Transceiver power enable
  output logic [1:0]       op_mode,             // Current operating mode
  output logic             ber_enable,          // Bit error test enable
  output logic [2:0]       supply_test_select   // Supply test mode select
);

  typedef enum logic {
    RST_RUN,
    RST_HELD
  } rst_state_e;

  rst_state_e  rst_state_reg;
  logic        hdr_pulse;
  logic        hdr_read;
  logic [5:0]  hdr_addr;
  logic        wr_pulse;
  logic [15:0] wr_data;
  logic        ce_active;
  logic        miso_w;
  logic        miso_oe_w;
  logic [15:0] rd_next;
  logic        reg_clear;
  logic        trigger_write;
  logic        reset_ind_reg;
  logic [6:0]  gpio_s1_reg;
  logic [6:0]  gpio_s2_reg;

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  spi_frame_slave u_spi (
    .clk       (clk),
    .rst       (rst),
    .sclk_pin  (spi_clk),
    .mosi_pin  (spi_mosi),
    .ce_n_pin  (spi_ce_n),
    .rd_data   (rd_next),
    .hdr_pulse (hdr_pulse),
    .hdr_read  (hdr_read),
    .hdr_addr  (hdr_addr),
    .wr_pulse  (wr_pulse),
    .wr_data   (wr_data),
    .ce_active (ce_active),
    .miso      (miso_w),
    .miso_oe   (miso_oe_w)
  );

  assign spi_miso    = miso_w;
  assign spi_miso_oe = miso_oe_w;

  // ----------------------------------------------------------------
  // Soft reset control
  // ----------------------------------------------------------------
  assign trigger_write = wr_pulse && hdr_addr == soft_reset_pkg::OFS_SOFTWARE_RESET_TRIGGER; // R1
  assign reg_clear     = rst || trigger_write || rst_state_reg == RST_HELD;               // R4

  always_ff @(posedge clk) begin
    if (rst) begin
      rst_state_reg <= RST_RUN;
    end else begin
      case (rst_state_reg)
        RST_RUN: begin
          if (trigger_write) begin // R1
            rst_state_reg <= RST_HELD;
          end
        end
        RST_HELD: begin
          if (!ce_active) begin // R7
            rst_state_reg <= RST_RUN;
          end
        end
        default: begin
          rst_state_reg <= RST_RUN;
        end
      endcase
    end
  end

  // Core reset follows the hold state; the packet memories never see it
  always_ff @(posedge clk) begin // R5
    if (rst) begin
      logic_reset <= 1'b1;
    end else begin
      logic_reset <= trigger_write || (rst_state_reg == RST_HELD && ce_active); // R6
    end
  end

  // Transceiver power is untouched by the soft reset
  always_ff @(posedge clk) begin
    if (rst) begin
      radio_powered <= 1'b0;
    end else begin
      radio_powered <= 1'b1; // R2
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reg_clear) begin
      op_mode <= soft_reset_pkg::MODE_IDLE; // R3
    end else if (op_mode == soft_reset_pkg::MODE_IDLE && rx_start) begin
      op_mode <= soft_reset_pkg::MODE_RECEIVE;
    end else if (op_mode == soft_reset_pkg::MODE_IDLE && tx_start) begin
      op_mode <= soft_reset_pkg::MODE_TRANSMIT;
    end else if (seq_done) begin
      op_mode <= soft_reset_pkg::MODE_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Writable test registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reg_clear) begin
      ber_enable         <= soft_reset_pkg::BER_EN_RST;     // R4
      supply_test_select <= soft_reset_pkg::SUPPLY_SEL_RST; // R4
    end else if (wr_pulse) begin
      if (hdr_addr == soft_reset_pkg::OFS_BIT_ERROR_TEST_ENABLE) begin
        ber_enable <= wr_data[soft_reset_pkg::BER_EN_BIT];
      end
      if (hdr_addr == soft_reset_pkg::OFS_POWER_SUPPLY_TEST_MODE) begin
        supply_test_select <= wr_data[soft_reset_pkg::SUPPLY_SEL_LSB +: 3];
      end
    end
  end

  // Reset indicator: set by any reset, cleared by reading it; set wins
  always_ff @(posedge clk) begin
    if (reg_clear) begin
      reset_ind_reg <= 1'b1;
    end else if (hdr_pulse && hdr_read && hdr_addr == soft_reset_pkg::OFS_RESET_INDICATOR) begin
      reset_ind_reg <= 1'b0;
    end
  end

  // GPIO pins come from outside the clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_s1_reg <= 7'h00;
      gpio_s2_reg <= 7'h00;
    end else begin
      gpio_s1_reg <= gpio_pins;
      gpio_s2_reg <= gpio_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read mux; the trigger register reads zero and reading it does nothing
  // ----------------------------------------------------------------
  always_comb begin
    rd_next = 16'h0000;
    case (hdr_addr)
      soft_reset_pkg::OFS_SOFTWARE_RESET_TRIGGER: rd_next = soft_reset_pkg::RESET_TRIGGER_RST; // R9 R8
      soft_reset_pkg::OFS_INTERRUPT_STATUS:       rd_next = irq_flags;
      soft_reset_pkg::OFS_RESET_INDICATOR:        rd_next[soft_reset_pkg::RESET_IND_BIT] = reset_ind_reg;
      soft_reset_pkg::OFS_CURRENT_TIME_HIGH:      rd_next[7:0] = current_time[23:16];
      soft_reset_pkg::OFS_CURRENT_TIME_LOW:       rd_next = current_time[15:0];
      soft_reset_pkg::OFS_GPIO_INPUT_LEVELS:      rd_next[soft_reset_pkg::GPIO_IN_LSB +: 7] = gpio_s2_reg;
      soft_reset_pkg::OFS_PART_IDENTIFIER:        rd_next = soft_reset_pkg::PART_ID_VALUE;
      soft_reset_pkg::OFS_RECEIVE_STATUS:         rd_next = {cca_final, 1'b0, rx_pkt_length};
      soft_reset_pkg::OFS_PACKET_TIMESTAMP_HIGH:  rd_next[7:0] = timestamp[23:16];
      soft_reset_pkg::OFS_PACKET_TIMESTAMP_LOW:   rd_next = timestamp[15:0];
      soft_reset_pkg::OFS_BIT_ERROR_TEST_ENABLE:  rd_next[soft_reset_pkg::BER_EN_BIT] = ber_enable;
      soft_reset_pkg::OFS_POWER_SUPPLY_TEST_MODE: rd_next[soft_reset_pkg::SUPPLY_SEL_LSB +: 3] = supply_test_select;
      default:                                    rd_next = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_trigger_holds: assert property (trigger_write |=> rst_state_reg == RST_HELD) // R1
    else $error("reset write did not enter hold");
  a_radio_stays: assert property (rst_state_reg == RST_HELD |-> radio_powered) // R2
    else $error("radio lost power in soft reset");
  a_mode_idle: assert property (rst_state_reg == RST_HELD |=> op_mode == soft_reset_pkg::MODE_IDLE) // R3
    else $error("mode not idle during soft reset");
  a_regs_default: assert property (trigger_write |=> ber_enable == soft_reset_pkg::BER_EN_RST // R4
                                   && supply_test_select == soft_reset_pkg::SUPPLY_SEL_RST)
    else $error("test registers not defaulted");
  a_ind_set: assert property (trigger_write |=> reset_ind_reg) // R4
    else $error("reset indicator not set by soft reset");
  a_hold_ce_low: assert property (rst_state_reg == RST_HELD && ce_active |=> logic_reset) // R6
    else $error("core reset released while chip enable low");
  a_release_ce: assert property (rst_state_reg == RST_HELD && !ce_active |=> rst_state_reg == RST_RUN ##1 !logic_reset) // R7
    else $error("soft reset not released after chip enable rose");
  a_read_no_effect: assert property (hdr_pulse && hdr_read && rst_state_reg == RST_RUN // R8
                                     && hdr_addr == soft_reset_pkg::OFS_SOFTWARE_RESET_TRIGGER
                                     |=> (rst_state_reg == RST_RUN) [*2])
    else $error("read of trigger register caused reset");
  a_trigger_zero: assert property (hdr_pulse && hdr_addr == soft_reset_pkg::OFS_SOFTWARE_RESET_TRIGGER // R9
                                   |-> rd_next == soft_reset_pkg::RESET_TRIGGER_RST)
    else $error("trigger register read not zero");
  // A port cleared by the soft reset would decode the tail of its own frame again
  a_port_alive: assert property (rst_state_reg == RST_HELD && ce_active |-> !hdr_pulse && !wr_pulse) // R10
    else $error("serial port restarted during soft reset");
  a_oe_read_only: assert property (miso_oe_w |-> hdr_read) // R10
    else $error("data out driven outside a read frame");

  c_soft_reset: cover property (trigger_write ##[1:200] rst_state_reg == RST_RUN);
  c_read_status: cover property (hdr_pulse && hdr_read && hdr_addr == soft_reset_pkg::OFS_INTERRUPT_STATUS);
  c_write_ber: cover property (wr_pulse && hdr_addr == soft_reset_pkg::OFS_BIT_ERROR_TEST_ENABLE);
  c_read_trigger: cover property (hdr_pulse && hdr_read
                                  && hdr_addr == soft_reset_pkg::OFS_SOFTWARE_RESET_TRIGGER);
  c_reset_release: cover property (rst_state_reg == RST_HELD ##1 rst_state_reg == RST_RUN);

endmodule // soft_reset_regs

// ==== testbench/spi_host_model.sv ====
// Host side serial master that frames 24-bit transfers for the register bank
`timescale 1ns/1ps
module spi_host_model #(
  parameter int HALF = 6                    // Serial clock half period in system clocks
) (
  input  wire logic clk,                    // System clock, used only for pacing
  output logic      spi_clk,                // Serial clock, idles low
  output logic      spi_mosi,               // Serial data to device
  output logic      spi_ce_n,               // Chip enable, active low
  input  wire logic spi_miso                // Serial data from device
);
  initial begin
    spi_clk  = 1'b0;
    spi_mosi = 1'b0;
    spi_ce_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // One frame: 8 header bits then 16 data bits, MSB first
  // ----------------------------------------------------------------
  // Hold keeps chip enable low after the last bit, which stretches a soft reset
  task automatic frame(input logic [7:0] hdr, input logic [15:0] wd, input int hold, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {hdr, wd};
    rd = 16'h0000;
    @(negedge clk);
    spi_ce_n = 1'b0;
    repeat (HALF) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      spi_mosi = sh[i];
      repeat (HALF) @(negedge clk);
      spi_clk = 1'b1;
      if (i < 16) begin
        rd[i] = spi_miso;
      end
      repeat (HALF) @(negedge clk);
      spi_clk = 1'b0;
    end
    // Released data line has no pull, so it must not keep looking valid
    spi_mosi = ~spi_mosi;
    repeat (hold) @(negedge clk);
    spi_ce_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule // spi_host_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the soft reset and status register bank
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        rst;
  logic        spi_clk;
  logic        spi_mosi;
  logic        spi_ce_n;
  logic        spi_miso;
  logic        spi_miso_oe;
  logic [15:0] irq_flags;
  logic [23:0] current_time;
  logic [6:0]  gpio_pins;
  logic [7:0]  cca_final;
  logic [6:0]  rx_pkt_length;
  logic [23:0] timestamp;
  logic        rx_start;
  logic        tx_start;
  logic        seq_done;
  logic        logic_reset;
  logic        radio_powered;
  logic [1:0]  op_mode;
  logic        ber_enable;
  logic [2:0]  supply_test_select;
  logic        lr_seen;
  logic        radio_drop;
  logic        oe_seen;
  int          n_mismatch;
  int          check_count;
  logic [5:0]  ofs_t [9];
  logic [15:0] exp_t [9];
  logic [15:0] rdat;

  soft_reset_regs soft_reset_regs_inst (.clk(clk), .rst(rst), .spi_clk(spi_clk), .spi_mosi(spi_mosi),
    .spi_ce_n(spi_ce_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .irq_flags(irq_flags),
    .current_time(current_time), .gpio_pins(gpio_pins), .cca_final(cca_final), .rx_pkt_length(rx_pkt_length),
    .timestamp(timestamp), .rx_start(rx_start), .tx_start(tx_start), .seq_done(seq_done),
    .logic_reset(logic_reset), .radio_powered(radio_powered), .op_mode(op_mode), .ber_enable(ber_enable),
    .supply_test_select(supply_test_select));

  spi_host_model spi_host_model_inst (.clk(clk), .spi_clk(spi_clk), .spi_mosi(spi_mosi), .spi_ce_n(spi_ce_n),
    .spi_miso(spi_miso));

  always #2.5 clk = ~clk;

  // Sticky monitors, cleared by the main sequence before each look
  always @(posedge clk) begin
    if (logic_reset === 1'b1) lr_seen <= 1'b1;
    if (!rst && radio_powered !== 1'b1) radio_drop <= 1'b1;
    if (spi_miso_oe === 1'b1) oe_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Access and comparison tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp, input string name);
    logic [15:0] d;
    oe_seen = 1'b0;
    spi_host_model_inst.frame({2'b10, a}, 16'h0000, 2, d);
    chk(name, exp, d);
    chk("miso_oe_read", 16'h0001, {15'h0, oe_seen});
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] v, input int hold);
    logic [15:0] d;
    oe_seen = 1'b0;
    spi_host_model_inst.frame({2'b00, a}, v, hold, d);
    chk("miso_oe_write", 16'h0000, {15'h0, oe_seen});
  endtask

  task automatic pulse_mode(input int sel, input logic [1:0] exp);
    @(negedge clk);
    rx_start = (sel == 0);
    tx_start = (sel == 1);
    seq_done = (sel == 2);
    @(negedge clk);
    {rx_start, tx_start, seq_done} = 3'h0;
    repeat (2) @(negedge clk);
    chk("op_mode", {14'h0, exp}, {14'h0, op_mode});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {rx_start, tx_start, seq_done} = 3'h0;
    irq_flags = 16'ha5c3;
    current_time = 24'h3c1234;
    gpio_pins = 7'h55;
    cca_final = 8'h9e;
    rx_pkt_length = 7'h2b;
    timestamp = 24'h7b0f1e;
    lr_seen = 1'b0;
    radio_drop = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    ofs_t = '{6'h24, 6'h26, 6'h27, 6'h28, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h3f};
    exp_t = '{16'ha5c3, 16'h003c, 16'h1234, 16'h5500, soft_reset_pkg::PART_ID_VALUE, 16'h9e2b, 16'h007b,
              16'h0f1e, 16'h0000};
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("radio_powered", 16'h0001, {15'h0, radio_powered});
    rd_chk(6'h25, 16'h0080, "reset_indicator");
    rd_chk(6'h25, 16'h0000, "reset_indicator_cleared");
    lr_seen = 1'b0;
    rd_chk(soft_reset_pkg::OFS_SOFTWARE_RESET_TRIGGER, soft_reset_pkg::RESET_TRIGGER_RST, "trigger_read");
    chk("read_side_effect", 16'h0000, {15'h0, lr_seen});
    wr(soft_reset_pkg::OFS_INTERRUPT_STATUS, 16'hffff, 2);
    for (int i = 0; i < 9; i++) begin
      rd_chk(ofs_t[i], exp_t[i], "status_read");
    end
    pulse_mode(1, 2'h2);
    pulse_mode(2, 2'h0);
    // Two soft resets with data words 0000 and a55a: the data must not matter
    for (int k = 0; k < 2; k++) begin
      wr(soft_reset_pkg::OFS_BIT_ERROR_TEST_ENABLE, 16'hffff, 2);
      wr(soft_reset_pkg::OFS_POWER_SUPPLY_TEST_MODE, 16'hffff, 2);
      rd_chk(soft_reset_pkg::OFS_BIT_ERROR_TEST_ENABLE, 16'h8000, "ber_readback");
      rd_chk(soft_reset_pkg::OFS_POWER_SUPPLY_TEST_MODE, 16'h001c, "supply_readback");
      chk("test_outputs", 16'h000f, {12'h0, ber_enable, supply_test_select});
      pulse_mode(0, 2'h1);
      radio_drop = 1'b0;
      fork
        wr(soft_reset_pkg::OFS_SOFTWARE_RESET_TRIGGER, (k == 0) ? 16'h0000 : 16'ha55a, 40);
        begin
          repeat (320) @(negedge clk);
          chk("logic_reset_hold", 16'h0001, {15'h0, logic_reset});
          chk("op_mode_idle", 16'h0000, {14'h0, op_mode});
        end
      join
      for (int w = 0; w < 20 && logic_reset !== 1'b0; w++) @(negedge clk);
      chk("logic_reset_release", 16'h0000, {15'h0, logic_reset});
      if (logic_reset !== 1'b0) wrap_up();
      chk("radio_kept", 16'h0000, {15'h0, radio_drop});
      chk("test_outputs_reset", 16'h0000, {12'h0, ber_enable, supply_test_select});
      rd_chk(soft_reset_pkg::OFS_BIT_ERROR_TEST_ENABLE, 16'h0000, "ber_default");
      rd_chk(soft_reset_pkg::OFS_POWER_SUPPLY_TEST_MODE, 16'h0000, "supply_default");
      rd_chk(soft_reset_pkg::OFS_RESET_INDICATOR, 16'h0080, "reset_indicator_soft");
      rd_chk(6'h24, 16'ha5c3, "status_after_reset");
    end
    wrap_up();
  end
endmodule // tb_top
